// ### logic/facr_regs.sv
// register bank: acoustic ramp setup, freewheel trigger, fan map
// assumes single-cycle strobes; read data valid the cycle after
// Operation
// - bit 0 of the acoustic register enables smoothing on channel 3.
// - bit 1 of the acoustic register enables smoothing on channel 4.
// - bits 4 to 2 pick the ramp rate of channel 3, reset 000.
// - bits 7 to 5 pick the ramp rate of channel 4, reset 000.
// - rate codes 0 to 7 give steps 1,2,3,5,8,12,24,48 per slot.
// - writing 1 to a freewheel bit starts that test; it self clears.
// - all three registers are 0x00 at reset and on software reinit.
// - freewheel test length comes from the spin-up timeout code.
// - the slow bit stretches the ramp slot by four.
module facr_regs (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        software_reinit,
  input  wire logic        reg_lock,
  // register port
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  output logic      [7:0]  rdata,
  // per-channel inputs
  input  wire logic [1:0]  slow_ramp,
  input  wire logic [7:0]  target_duty_ch3,
  input  wire logic [7:0]  target_duty_ch4,
  input  wire logic [23:0] spinup_timeout,
  // outputs
  output logic      [7:0]  duty_ch3,
  output logic      [7:0]  duty_ch4,
  output logic      [7:0]  freewheel_active,
  output logic      [7:0]  fan_installed
);
  logic [7:0]  acoustic_reg;
  logic [7:0]  fwtest_reg;
  logic [7:0]  fanmap_reg;
  logic        lock_reg;
  logic        wr_ok;
  logic [31:0] slot_cnt_reg;
  logic        base_tick;
  logic [1:0]  slow_cnt_reg [2];
  logic [1:0]  slot_tick;

  assign wr_ok = wr_en && !lock_reg;

  // lock holds until the next power-on reset, not software reinit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_reg <= 1'b0;
    end else if (reg_lock) begin
      lock_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || software_reinit) begin
      acoustic_reg <= facr_pkg::FACR_RESET_VAL;
    end else if (wr_ok && addr == facr_pkg::FACR_ADDR_ACOUSTIC) begin
      acoustic_reg <= wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n || software_reinit) begin
      fanmap_reg <= facr_pkg::FACR_RESET_VAL;
    end else if (wr_ok && addr == facr_pkg::FACR_ADDR_FANMAP) begin
      fanmap_reg <= wdata;
    end
  end
  assign fan_installed = fanmap_reg;

  // base slot tick shared by both ramp channels
  always_ff @(posedge clk) begin
    if (!rst_n || slot_cnt_reg == 32'(facr_pkg::FACR_SLOT_CYC - 1)) begin
      slot_cnt_reg <= 32'h0;
    end else begin
      slot_cnt_reg <= slot_cnt_reg + 32'h1;
    end
  end
  assign base_tick = slot_cnt_reg == 32'(facr_pkg::FACR_SLOT_CYC - 1);

  genvar c;
  generate
    for (c = 0; c < 2; c++) begin : g_slow
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          slow_cnt_reg[c] <= 2'h0;
        end else if (base_tick) begin
          slow_cnt_reg[c] <= slow_cnt_reg[c] + 2'h1;
        end
      end
      // slow mode passes every fourth base tick
      assign slot_tick[c] = base_tick && (!slow_ramp[c] ||
        slow_cnt_reg[c] == 2'(facr_pkg::FACR_SLOW_FACTOR - 1));
    end
  endgenerate

  facr_ramp u_ramp3 (
    .clk         (clk),
    .rst_n       (rst_n),
    .smooth_on   (acoustic_reg[facr_pkg::FACR_EN3_BIT]),
    .rate_code   (acoustic_reg[facr_pkg::FACR_RATE3_LSB +: 3]),
    .slot_tick   (slot_tick[0]),
    .target_duty (target_duty_ch3),
    .duty_out    (duty_ch3)
  );

  facr_ramp u_ramp4 (
    .clk         (clk),
    .rst_n       (rst_n),
    .smooth_on   (acoustic_reg[facr_pkg::FACR_EN4_BIT]),
    .rate_code   (acoustic_reg[facr_pkg::FACR_RATE4_LSB +: 3]),
    .slot_tick   (slot_tick[1]),
    .target_duty (target_duty_ch4),
    .duty_out    (duty_ch4)
  );

  // freewheel test: one timer per fan
  genvar f;
  generate
    for (f = 0; f < facr_pkg::FACR_NUM_FANS; f++) begin : g_fw
      logic [31:0] to_cyc;
      logic [31:0] tcnt_reg;
      logic        done;
      always_comb begin
        unique case (spinup_timeout[3*f +: 3])
          3'h0: to_cyc = 32'h0;
          3'h1: to_cyc = 32'(facr_pkg::FACR_TO_MS1 * facr_pkg::FACR_MS_CYC);
          3'h2: to_cyc = 32'(facr_pkg::FACR_TO_MS2 * facr_pkg::FACR_MS_CYC);
          3'h3: to_cyc = 32'(facr_pkg::FACR_TO_MS3 * facr_pkg::FACR_MS_CYC);
          3'h4: to_cyc = 32'(facr_pkg::FACR_TO_MS4 * facr_pkg::FACR_MS_CYC);
          3'h5: to_cyc = 32'(facr_pkg::FACR_TO_MS5 * facr_pkg::FACR_MS_CYC);
          3'h6: to_cyc = 32'(facr_pkg::FACR_TO_MS6 * facr_pkg::FACR_MS_CYC);
          3'h7: to_cyc = 32'(facr_pkg::FACR_TO_MS7 * facr_pkg::FACR_MS_CYC);
        endcase
      end
      // no-timeout code ends the test after one cycle
      assign done = fwtest_reg[f] && (tcnt_reg + 32'h1 >= to_cyc);
      always_ff @(posedge clk) begin
        if (!rst_n || !fwtest_reg[f]) begin
          tcnt_reg <= 32'h0;
        end else begin
          tcnt_reg <= tcnt_reg + 32'h1;
        end
      end
      // a new write of 1 in the finishing cycle wins over the self clear
      always_ff @(posedge clk) begin
        if (!rst_n || software_reinit) begin
          fwtest_reg[f] <= facr_pkg::FACR_RESET_VAL[f];
        end else if (wr_ok && addr == facr_pkg::FACR_ADDR_FWTEST) begin
          fwtest_reg[f] <= wdata[f];
        end else if (done) begin
          fwtest_reg[f] <= 1'b0;
        end
      end
    end
  endgenerate
  assign freewheel_active = fwtest_reg;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (rd_en) begin
      unique case (addr)
        facr_pkg::FACR_ADDR_ACOUSTIC: rdata <= acoustic_reg;
        facr_pkg::FACR_ADDR_FWTEST:   rdata <= fwtest_reg;
        facr_pkg::FACR_ADDR_FANMAP:   rdata <= fanmap_reg;
        default:                      rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  property p_reinit_clears;
    @(posedge clk) disable iff (!rst_n)
      software_reinit |=> acoustic_reg == 8'h00 && fanmap_reg == 8'h00 &&
      fwtest_reg == 8'h00;
  endproperty
  a_reinit_clears: assert property (p_reinit_clears)
    else $error("registers not cleared by reinit");

  property p_lock_blocks;
    @(posedge clk) disable iff (!rst_n)
      lock_reg && !software_reinit |=> $stable(fanmap_reg);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks)
    else $error("locked register changed");

  property p_map_write;
    @(posedge clk) disable iff (!rst_n)
      wr_ok && !software_reinit && addr == facr_pkg::FACR_ADDR_FANMAP
      |=> fanmap_reg == $past(wdata);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("fan map did not take write");

  property p_duty_limit;
    @(posedge clk) disable iff (!rst_n)
      acoustic_reg[0] && $past(acoustic_reg[0]) && duty_ch3 > $past(duty_ch3)
      |-> duty_ch3 - $past(duty_ch3) <= 8'h30;
  endproperty
  a_duty_limit: assert property (p_duty_limit)
    else $error("ramp step too large");

  property p_ramp_off;
    @(posedge clk) disable iff (!rst_n)
      // sampled reset keeps the release edge out, when duty is still zero
      rst_n && !acoustic_reg[1] && $stable(target_duty_ch4) &&
      !$past(acoustic_reg[1]) |=> duty_ch4 == $past(target_duty_ch4);
  endproperty
  a_ramp_off: assert property (p_ramp_off)
    else $error("duty not direct with smoothing off");

  property p_no_tick_hold;
    @(posedge clk) disable iff (!rst_n)
      acoustic_reg[0] && !slot_tick[0] && target_duty_ch3 > duty_ch3
      |=> duty_ch3 == $past(duty_ch3);
  endproperty
  a_no_tick_hold: assert property (p_no_tick_hold)
    else $error("duty moved without slot");

  property p_slow_tick;
    @(posedge clk) disable iff (!rst_n)
      slow_ramp[0] && slot_tick[0] |-> slow_cnt_reg[0] == 2'h3;
  endproperty
  a_slow_tick: assert property (p_slow_tick)
    else $error("slow ramp ticked early");

  property p_fw_clear;
    @(posedge clk) disable iff (!rst_n)
      g_fw[0].done && !wr_ok && !software_reinit |=> !fwtest_reg[0];
  endproperty
  a_fw_clear: assert property (p_fw_clear)
    else $error("freewheel bit did not self clear");

  property p_fw_zero_to;
    @(posedge clk) disable iff (!rst_n)
      fwtest_reg[1] && spinup_timeout[5:3] == 3'h0 |-> g_fw[1].done;
  endproperty
  a_fw_zero_to: assert property (p_fw_zero_to)
    else $error("no-timeout test not ended");
endmodule

// ### logic/facr_pkg.sv
// package for the fan acoustics and test register bank
// assumes a 25 MHz clock and an 8-bit register port
package facr_pkg;
  localparam logic [7:0] FACR_ADDR_ACOUSTIC = 8'h1B;
  localparam logic [7:0] FACR_ADDR_FWTEST   = 8'h1C;
  localparam logic [7:0] FACR_ADDR_FANMAP   = 8'h1D;
  localparam logic [7:0] FACR_RESET_VAL     = 8'h00;
  localparam int         FACR_EN3_BIT       = 0;
  localparam int         FACR_EN4_BIT       = 1;
  localparam int         FACR_RATE3_LSB     = 2;
  localparam int         FACR_RATE4_LSB     = 5;
  localparam int         FACR_NUM_FANS      = 8;
  // time slot of the ramp, figure in ms
  // 200 ms slots make a one-step ramp from a third to full duty ~34 s
  localparam int         FACR_CLK_HZ        = 25000000;
  localparam int         FACR_SLOT_MS       = 200;
  localparam int         FACR_SLOT_CYC      = FACR_SLOT_MS * (FACR_CLK_HZ / 1000);
  localparam int         FACR_SLOW_FACTOR   = 4;
  // freewheel timeouts in ms, code 001..111
  localparam int         FACR_TO_MS1        = 100;
  localparam int         FACR_TO_MS2        = 250;
  localparam int         FACR_TO_MS3        = 400;
  localparam int         FACR_TO_MS4        = 667;
  localparam int         FACR_TO_MS5        = 1000;
  localparam int         FACR_TO_MS6        = 2000;
  localparam int         FACR_TO_MS7        = 32000;
  localparam int         FACR_MS_CYC        = FACR_CLK_HZ / 1000;
  typedef enum logic [1:0] {FACR_IDLE, FACR_RUN} facr_test_t;
endpackage

// ### logic/facr_ramp.sv
// one duty ramp channel for the acoustic smoothing mode
// assumes a slot tick from the register bank
module facr_ramp (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // control
  input  wire logic       smooth_on,
  input  wire logic [2:0] rate_code,
  input  wire logic       slot_tick,
  input  wire logic [7:0] target_duty,
  // result
  output logic      [7:0] duty_out
);
  logic [7:0] step;
  logic [8:0] sum;

  always_comb begin
    unique case (rate_code)
      3'h0: step = 8'h01;
      3'h1: step = 8'h02;
      3'h2: step = 8'h03;
      3'h3: step = 8'h05;
      3'h4: step = 8'h08;
      3'h5: step = 8'h0C;
      3'h6: step = 8'h18;
      3'h7: step = 8'h30;
    endcase
  end

  assign sum = {1'b0, duty_out} + {1'b0, step};

  // falling duty is not smoothed, only rises are limited
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      duty_out <= 8'h00;
    end else if (!smooth_on || target_duty <= duty_out) begin
      duty_out <= target_duty;
    end else if (slot_tick) begin
      if (sum >= {1'b0, target_duty}) begin
        duty_out <= target_duty;
      end else begin
        duty_out <= sum[7:0];
      end
    end
  end
endmodule

// ### sim/facr_host_model.sv
// host software model: drives the register port of the bank
// assumes strobes taken at posedge, read data in the next cycle
module facr_host_model (
  // clock
  input  wire logic       clk,
  // register port
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr_en,
  output logic            rd_en,
  input  wire logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
  end
  // software sets trigger and fitted-fan bits by plain writes
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
endmodule

// ### sim/tb_facr_regs.sv
// testbench for the fan acoustics and test register bank
// assumes the host model drives the register port
module tb_facr_regs;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("MISMATCH %0t value differs", $time); end end
  logic        clk, rst_n, software_reinit, reg_lock, wr_en, rd_en;
  logic [7:0]  addr, wdata, rdata, rd_val, target_duty_ch3, target_duty_ch4;
  logic [1:0]  slow_ramp;
  logic [23:0] spinup_timeout;
  logic [7:0]  duty_ch3, duty_ch4, freewheel_active, fan_installed;
  int          errors, compares;
  always #20 clk = ~clk;
  facr_host_model facr_host_model_i (.clk(clk), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata));
  facr_regs facr_regs_i (.clk(clk), .rst_n(rst_n),
    .software_reinit(software_reinit), .reg_lock(reg_lock), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .slow_ramp(slow_ramp), .target_duty_ch3(target_duty_ch3),
    .target_duty_ch4(target_duty_ch4), .spinup_timeout(spinup_timeout),
    .duty_ch3(duty_ch3), .duty_ch4(duty_ch4),
    .freewheel_active(freewheel_active), .fan_installed(fan_installed));
  task automatic finish_test();
    $display("checks %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic reset_dut();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic pulse_reinit();
    @(posedge clk);
    software_reinit <= 1'b1;
    @(posedge clk);
    software_reinit <= 1'b0;
  endtask
  task automatic check_rd(input logic [7:0] a, input logic [7:0] e);
    facr_host_model_i.rd(a, rd_val);
    `CHK(rd_val, e)
  endtask
  task automatic test_reset();
    check_rd(8'h1B, 8'h00);
    check_rd(8'h1C, 8'h00);
    check_rd(8'h1D, 8'h00);
    check_rd(8'h1E, 8'h00);
    $display("test reset done");
  endtask
  task automatic test_acoustic();
    logic [7:0] v;
    for (int c = 0; c < 8; c++) begin
      v = {3'(c), 3'(7 - c), 2'(c)};
      facr_host_model_i.wr(8'h1B, v);
      check_rd(8'h1B, v);
    end
    $display("test acoustic done");
  endtask
  task automatic test_fanmap();
    facr_host_model_i.wr(8'h1D, 8'hA5);
    @(posedge clk);
    `CHK(fan_installed, 8'hA5)
    check_rd(8'h1D, 8'hA5);
    facr_host_model_i.wr(8'h1D, 8'h5A);
    check_rd(8'h1D, 8'h5A);
    $display("test fanmap done");
  endtask
  task automatic test_freewheel();
    int n;
    // fan 7 gets the 100 ms code, far longer than the wait below
    spinup_timeout <= {3'h1, 21'h000000};
    facr_host_model_i.wr(8'h1C, 8'h83);
    @(posedge clk);
    `CHK(freewheel_active, 8'h83)
    n = 0;
    while (freewheel_active[1:0] !== 2'h0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n == 50) begin
      errors++;
      $display("MISMATCH %0t freewheel bits never cleared", $time);
      finish_test();
    end
    `CHK(freewheel_active, 8'h80)
    repeat (200) @(posedge clk);
    check_rd(8'h1C, 8'h80);
    pulse_reinit();
    check_rd(8'h1C, 8'h00);
    $display("test freewheel done");
  endtask
  task automatic test_ramp();
    facr_host_model_i.wr(8'h1B, 8'h00);
    target_duty_ch3 <= 8'h40;
    target_duty_ch4 <= 8'h20;
    repeat (2) @(posedge clk);
    `CHK(duty_ch3, 8'h40)
    `CHK(duty_ch4, 8'h20)
    facr_host_model_i.wr(8'h1B, 8'h03);
    target_duty_ch3 <= 8'hF0;
    target_duty_ch4 <= 8'h10;
    repeat (20) @(posedge clk);
    // no slot tick falls in this short window, so the rise must wait
    `CHK(duty_ch3, 8'h40)
    `CHK(duty_ch4, 8'h10)
    facr_host_model_i.wr(8'h1B, 8'h00);
    repeat (2) @(posedge clk);
    `CHK(duty_ch3, 8'hF0)
    $display("test ramp done");
  endtask
  task automatic test_lock();
    facr_host_model_i.wr(8'h1D, 8'h3C);
    facr_host_model_i.wr(8'h1B, 8'h1C);
    pulse_reinit();
    check_rd(8'h1D, 8'h00);
    check_rd(8'h1B, 8'h00);
    @(posedge clk);
    reg_lock <= 1'b1;
    @(posedge clk);
    reg_lock <= 1'b0;
    facr_host_model_i.wr(8'h1D, 8'hFF);
    check_rd(8'h1D, 8'h00);
    facr_host_model_i.wr(8'h1B, 8'hFF);
    check_rd(8'h1B, 8'h00);
    reset_dut();
    facr_host_model_i.wr(8'h1D, 8'h11);
    check_rd(8'h1D, 8'h11);
    $display("test lock done");
  endtask
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    software_reinit = 1'b0;
    reg_lock = 1'b0;
    slow_ramp = 2'h0;
    target_duty_ch3 = 8'h00;
    target_duty_ch4 = 8'h00;
    spinup_timeout = 24'h000000;
    errors = 0;
    compares = 0;
    reset_dut();
    test_reset();
    test_acoustic();
    test_fanmap();
    test_freewheel();
    test_ramp();
    test_lock();
    finish_test();
  end
endmodule
